// ==== core/dbss_pkg.sv ====
// Purpose: Shared constants and types of the brake and stop sequencer
// Assumes: 10 MHz clock, voltages in volts, speed in rpm, current limit in 0.1 A
// Notes: Supply class 0/1/2 selects the 230/400/480 V threshold sets
package dbss_pkg;
   localparam int unsigned CLK_HZ = 10_000_000;
   localparam int unsigned DISABLE_DELAY_MS = 100;
   localparam int unsigned SETPOINT_RAMP_MS = 10;
   localparam int unsigned EMERGENCY_TIMEOUT_MS = 5000;
   localparam int unsigned DISABLE_DELAY_CYC = CLK_HZ / 1000 * DISABLE_DELAY_MS;
   localparam int unsigned SETPOINT_RAMP_CYC = CLK_HZ / 1000 * SETPOINT_RAMP_MS;
   localparam int unsigned EMERGENCY_TIMEOUT_CYC = CLK_HZ / 1000 * EMERGENCY_TIMEOUT_MS;
   localparam logic [15:0] BRAKE_SPEED_RPM = 16'h0005;
   localparam logic [15:0] PHASE_LOSS_ILIM_DA = 16'h0028;
   localparam logic [15:0] ILIM_FULL = 16'hffff;
   localparam logic [15:0] SETPOINT_RST = 16'h0000;
   // Supply class: 0 = 3x230 V, 1 = 3x400 V, 2 = 3x480 V
   localparam logic [15:0] REGEN_ON_V0 = 16'h0190;
   localparam logic [15:0] REGEN_ON_V1 = 16'h02d0;
   localparam logic [15:0] REGEN_ON_V2 = 16'h0348;
   localparam logic [15:0] REGEN_OFF_V0 = 16'h017c;
   localparam logic [15:0] REGEN_OFF_V1 = 16'h02a8;
   localparam logic [15:0] REGEN_OFF_V2 = 16'h0320;
   localparam logic [15:0] OVERVOLT_V0 = 16'h01c2;
   localparam logic [15:0] OVERVOLT_V1 = 16'h0320;
   localparam logic [15:0] OVERVOLT_V2 = 16'h0384;
   typedef enum logic [1:0] {DBSS_RUN, DBSS_DELAY, DBSS_COAST, DBSS_HELD} dbss_state_t;
endpackage

// ==== core/dbss_regen_if.sv ====
// Purpose: Carrier between sequencer and regen/overvoltage checker
// Assumes: Single clock domain
// Notes: Thresholds travel already chosen by supply class
`timescale 1ns/1ps
`default_nettype none
interface dbss_regen_if;
   logic [15:0] bus_voltage;
   logic [15:0] on_level;
   logic [15:0] off_level;
   logic [15:0] ov_level;
   logic power_exceeded;
   logic bus_check;
   logic regen_on;
   logic power_flag;
   logic overvolt;
   modport checker_side (input bus_voltage, on_level, off_level, ov_level, power_exceeded,
      bus_check, output regen_on, power_flag, overvolt);
   modport seq_side (output bus_voltage, on_level, off_level, ov_level, power_exceeded,
      bus_check, input regen_on, power_flag, overvolt);
endinterface
`default_nettype wire

// ==== core/dbss_regen.sv ====
// Purpose: Regen resistor hysteresis switch and periodic overvoltage check
// Assumes: Bus voltage already synchronous to clk
// Notes: Power flag and overvoltage latch until reset
`timescale 1ns/1ps
`default_nettype none
module dbss_regen (
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Sequencer side
   dbss_regen_if.checker_side rg
);
   import dbss_pkg::*;
   logic regen_r, regen_nxt;
   logic power_r, ov_r;
   wire logic at_on = rg.bus_voltage >= rg.on_level;
   wire logic at_off = rg.bus_voltage <= rg.off_level;
   assign regen_nxt = (power_r || rg.power_exceeded) ? 1'b0 :
      at_on ? 1'b1 :
      at_off ? 1'b0 : regen_r;
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         regen_r <= 1'b0;
         power_r <= 1'b0;
         ov_r <= 1'b0;
      end else begin
         regen_r <= regen_nxt;
         power_r <= power_r | rg.power_exceeded;
         // Checked only on the periodic strobe, not every cycle
         if (rg.bus_check && rg.bus_voltage >= rg.ov_level) begin
            ov_r <= 1'b1;
         end
      end
   end
   assign rg.regen_on = regen_r;
   assign rg.power_flag = power_r;
   assign rg.overvolt = ov_r;
endmodule // dbss_regen
`default_nettype wire

// ==== core/dbss_top.sv ====
// Purpose: Holding-brake, stop-response and supply fault sequencer of a servo drive
// Assumes: Digital speed and bus voltage words from a converter on this clock
//          Only the two controller pins need synchronising
// Notes: Faults latch until reset_n; the restart lock is outside this block
//        With brake selected, enable removal keeps the stage on until the brake engages
//        The emergency timeout is counted from enable removal
// Function
// - Brake sequencing runs only with brake selected, otherwise the brake output stays off.
// - Enable removal with brake starts controlled braking with a 10 ms setpoint ramp to zero; the 100 ms disable delay applies only without brake.
// - Brake engages at 5 rpm or after the 5 s emergency timeout, whichever comes first.
// - Regen resistor switches on at the upper level of the supply class.
// - Regen resistor switches off at the lower level, giving hysteresis.
// - Excess brake power sets a status and stops regen switching.
// - Periodic bus check at 450/800/900 V disables the stage and reports overvoltage.
// - Ready contact opens together with the overvoltage shutdown.
// - Fault setting at 0, and stop setting at 0 without brake selected, let the motor coast without controlled braking.
// - Stop and fault settings at 1 brake the motor in a controlled way.
// - Phase loss warning mode raises a warning, limits current to 4 A, stays enabled.
// - Warning mode shows mains-ready error on an output for the controller to act on.
// - Phase loss error mode reports, disables, opens ready and uses the emergency ramp when the fault setting is 1.
// - Undervoltage reports an error and responds per the fault setting; the stop setting has no effect on it.
// - With brake selected, enable removal starts electrical braking before the brake engages.
`timescale 1ns/1ps
`default_nettype none
module dbss_top (
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Controller pins, asynchronous
   input wire logic enable_pin,
   input wire logic phase_loss_pin,
   // Configuration
   input wire logic brake_select,
   input wire logic stop_response_setting,
   input wire logic fault_response_setting,
   input wire logic phase_loss_response_mode,
   input wire logic [1:0] supply_class,
   // Measurements
   input wire logic [15:0] speed_rpm,
   input wire logic [15:0] speed_cmd,
   input wire logic [15:0] bus_voltage,
   input wire logic [15:0] undervolt_level,
   input wire logic bus_check,
   input wire logic power_exceeded,
   // Drive outputs
   output logic [15:0] speed_setpoint,
   output logic [15:0] current_limit,
   output logic stage_enable,
   output logic controlled_brake,
   output logic brake_out,
   output logic regen_on,
   output logic ready_contact,
   // Status
   output logic power_exceeded_status,
   output logic overvoltage_fault,
   output logic undervoltage_fault,
   output logic phase_loss_error,
   output logic phase_loss_warning,
   output logic mains_ready_error
);
   import dbss_pkg::*;
   dbss_regen_if rg();
   dbss_state_t state_r, state_nxt;
   logic en_s1_r, en_s2_r;
   logic pl_s1_r, pl_s2_r;
   logic [25:0] delay_cnt_r, delay_cnt_nxt;
   logic [25:0] emrg_cnt_r, emrg_cnt_nxt;
   logic [15:0] setpoint_r, setpoint_nxt;
   logic [15:0] ramp_step_r;
   logic brake_r, brake_nxt;
   logic uv_r, ple_r, plw_r;
   // Two-stage synchronisers; stage one is read only by stage two
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         en_s1_r <= 1'b0;
         en_s2_r <= 1'b0;
         pl_s1_r <= 1'b0;
         pl_s2_r <= 1'b0;
      end else begin
         en_s1_r <= enable_pin;
         en_s2_r <= en_s1_r;
         pl_s1_r <= phase_loss_pin;
         pl_s2_r <= pl_s1_r;
      end
   end
   // Threshold selection by supply class; class 3 falls back to the lowest set
   wire logic cls_mid = supply_class == 2'h1;
   wire logic cls_high = supply_class == 2'h2;
   assign rg.bus_voltage = bus_voltage;
   assign rg.on_level = cls_high ? REGEN_ON_V2 :
      cls_mid ? REGEN_ON_V1 : REGEN_ON_V0;
   assign rg.off_level = cls_high ? REGEN_OFF_V2 :
      cls_mid ? REGEN_OFF_V1 : REGEN_OFF_V0;
   assign rg.ov_level = cls_high ? OVERVOLT_V2 :
      cls_mid ? OVERVOLT_V1 : OVERVOLT_V0;
   assign rg.power_exceeded = power_exceeded;
   assign rg.bus_check = bus_check;
   // Regen switching and the overvoltage check live in their own module
   dbss_regen u_regen (
      .clk(clk),
      .reset_n(reset_n),
      .rg(rg)
   );
   // Fault classification
   wire logic pl_err_ev = pl_s2_r && phase_loss_response_mode;
   wire logic pl_warn_ev = pl_s2_r && !phase_loss_response_mode;
   wire logic uv_ev = bus_voltage < undervolt_level;
   // Overvoltage always drops the stage at once; other faults follow the fault setting
   wire logic hard_fault = rg.overvolt;
   wire logic soft_fault = ple_r || uv_r;
   wire logic fault_any = hard_fault || soft_fault;
   wire logic fault_brake = soft_fault && fault_response_setting;
   wire logic stop_req = !en_s2_r || soft_fault;
   wire logic resume = en_s2_r && !fault_any;
   wire logic controlled = soft_fault ? fault_brake :
      (stop_response_setting || brake_select);
   wire logic delay_done = delay_cnt_r >= 26'(DISABLE_DELAY_CYC - 1);
   wire logic speed_low = speed_rpm <= BRAKE_SPEED_RPM;
   wire logic emrg_done = emrg_cnt_r >= 26'(EMERGENCY_TIMEOUT_CYC - 1);
   // The brake waits for low speed or the timeout, not for the end of the delay
   wire logic engage = speed_low || emrg_done;
   wire logic brake_done = brake_select && engage;
   wire logic coast_done = !brake_select && delay_done;
   // Sequencer
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         DBSS_RUN: begin
            // A hard fault with brake selected clamps the brake at once
            if (hard_fault) begin
               state_nxt = brake_select ? DBSS_HELD : DBSS_COAST;
            end else if (stop_req) begin
               state_nxt = controlled ? DBSS_DELAY : DBSS_COAST;
            end
         end
         DBSS_DELAY: begin
            // Hard fault ends braking at once; the stage is already dropped
            if (hard_fault) begin
               state_nxt = brake_select ? DBSS_HELD : DBSS_COAST;
            end else if (brake_done) begin
               state_nxt = DBSS_HELD;
            end else if (coast_done) begin
               state_nxt = DBSS_COAST;
            end
         end
         DBSS_COAST: begin
            if (resume) begin
               state_nxt = DBSS_RUN;
            end
         end
         DBSS_HELD: begin
            if (resume) begin
               state_nxt = DBSS_RUN;
            end
         end
         default: state_nxt = DBSS_RUN;
      endcase
   end
   // Ramp from the value held at stop, reaching zero within the ramp time
   wire logic in_run = state_r == DBSS_RUN;
   wire logic in_delay = state_r == DBSS_DELAY;
   // Step rounds up in 32 bits so a large command still reaches zero in time
   wire logic [31:0] ramp_num = 32'(speed_cmd) + SETPOINT_RAMP_CYC - 32'h1;
   wire logic [31:0] ramp_quot = ramp_num / SETPOINT_RAMP_CYC;
   wire logic [15:0] ramp_down = (setpoint_r > ramp_step_r) ?
      setpoint_r - ramp_step_r : 16'h0000;
   assign delay_cnt_nxt = in_delay ? delay_cnt_r + 26'h1 : 26'h0;
   // Timeout runs from enable removal, so a stuck axis still gets its brake
   assign emrg_cnt_nxt = in_delay ? emrg_cnt_r + 26'h1 : 26'h0;
   // The ramp starts from the last command, not from zero
   assign setpoint_nxt = (state_nxt == DBSS_RUN) ? speed_cmd :
      (state_nxt != DBSS_DELAY) ? 16'h0000 :
      in_delay ? ramp_down : setpoint_r;
   // Brake is reached only through the delay or a hard fault
   assign brake_nxt = brake_select && (state_nxt == DBSS_HELD);
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         state_r <= DBSS_COAST;
         delay_cnt_r <= 26'h0;
         emrg_cnt_r <= 26'h0;
         setpoint_r <= SETPOINT_RST;
         ramp_step_r <= 16'h0000;
         brake_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         delay_cnt_r <= delay_cnt_nxt;
         emrg_cnt_r <= emrg_cnt_nxt;
         setpoint_r <= setpoint_nxt;
         if (in_run) begin
            ramp_step_r <= ramp_quot[15:0];
         end
         brake_r <= brake_nxt;
      end
   end
   // Latched faults and the unlatched warning; a new event wins over nothing since only reset clears the two faults
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         uv_r <= 1'b0;
         ple_r <= 1'b0;
         plw_r <= 1'b0;
      end else begin
         uv_r <= uv_r | uv_ev;
         ple_r <= ple_r | pl_err_ev;
         // Warning follows the pin, so the limit lifts by itself
         plw_r <= pl_warn_ev;
      end
   end
   assign speed_setpoint = setpoint_r;
   // Limit is in 0.1 A steps
   assign current_limit = plw_r ? PHASE_LOSS_ILIM_DA : ILIM_FULL;
   assign stage_enable = (in_run || in_delay) && !hard_fault;
   assign controlled_brake = in_delay;
   assign brake_out = brake_r;
   assign regen_on = rg.regen_on;
   assign ready_contact = !fault_any;
   assign power_exceeded_status = rg.power_flag;
   assign overvoltage_fault = rg.overvolt;
   assign undervoltage_fault = uv_r;
   assign phase_loss_error = ple_r;
   assign phase_loss_warning = plw_r;
   assign mains_ready_error = plw_r;
endmodule // dbss_top
`default_nettype wire

// ==== verification/dbss_chk.sv ====
// Purpose: Port-level assertions for the brake and stop sequencer
// Assumes: One clock, synchronous active-low reset
// Notes: Latency windows of one to three cycles follow the hand-over timing
`timescale 1ns/1ps
`default_nettype none
module dbss_chk (
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Inputs
   input wire logic brake_select,
   input wire logic enable_pin,
   input wire logic [1:0] supply_class,
   input wire logic [15:0] speed_rpm,
   input wire logic [15:0] bus_voltage,
   input wire logic bus_check,
   // Outputs
   input wire logic controlled_brake,
   input wire logic brake_out,
   input wire logic regen_on,
   input wire logic ready_contact,
   input wire logic stage_enable,
   input wire logic [15:0] current_limit,
   input wire logic power_exceeded_status,
   input wire logic overvoltage_fault,
   input wire logic undervoltage_fault,
   input wire logic phase_loss_error,
   input wire logic phase_loss_warning
);
   import dbss_pkg::*;
   wire logic c1 = supply_class == 2'h1;
   wire logic c2 = supply_class == 2'h2;
   wire logic [15:0] on_l = c1 ? REGEN_ON_V1 : c2 ? REGEN_ON_V2 : REGEN_ON_V0;
   wire logic [15:0] off_l = c1 ? REGEN_OFF_V1 : c2 ? REGEN_OFF_V2 : REGEN_OFF_V0;
   wire logic [15:0] ov_l = c1 ? OVERVOLT_V1 : c2 ? OVERVOLT_V2 : OVERVOLT_V0;
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   a_brake_needs_select: assert property ($rose(brake_out) |-> brake_select)
      else $error("brake engaged without brake selected");
   a_brake_low_speed: assert property (controlled_brake && brake_select
      && speed_rpm <= BRAKE_SPEED_RPM |-> ##[1:3] brake_out)
      else $error("brake not engaged at low speed");
   a_braking_before_brake: assert property ($rose(brake_out) && !overvoltage_fault
      |-> $past(controlled_brake))
      else $error("brake engaged without electrical braking first");
   a_brake_held_off: assert property (brake_out && !enable_pin |=> brake_out)
      else $error("brake released while enable is off");
   a_regen_on_level: assert property (!regen_on && bus_voltage >= on_l
      && !power_exceeded_status && !overvoltage_fault |-> ##[1:3] regen_on)
      else $error("regen not switched on at upper level");
   a_regen_off_level: assert property (regen_on && bus_voltage <= off_l
      |-> ##[1:3] !regen_on)
      else $error("regen not switched off at lower level");
   a_power_stops_regen: assert property ($rose(regen_on) |-> !power_exceeded_status)
      else $error("regen switched on after power exceeded");
   a_overvolt_check: assert property (bus_check && bus_voltage >= ov_l
      |-> ##[1:3] (overvoltage_fault && !stage_enable))
      else $error("overvoltage not caught at bus check");
   a_overvolt_ready: assert property (overvoltage_fault |-> !ready_contact)
      else $error("ready closed during overvoltage");
   a_warning_limit: assert property (phase_loss_warning
      |-> current_limit == PHASE_LOSS_ILIM_DA && stage_enable)
      else $error("warning without current limit or enable");
   a_soft_fault_ready: assert property (phase_loss_error || undervoltage_fault
      |-> !ready_contact)
      else $error("ready closed during supply fault");
endmodule // dbss_chk
bind dbss_top dbss_chk u_chk (.clk(clk), .reset_n(reset_n), .brake_select(brake_select),
   .enable_pin(enable_pin), .supply_class(supply_class), .speed_rpm(speed_rpm),
   .bus_voltage(bus_voltage), .bus_check(bus_check), .controlled_brake(controlled_brake),
   .brake_out(brake_out), .regen_on(regen_on), .ready_contact(ready_contact),
   .stage_enable(stage_enable), .current_limit(current_limit),
   .power_exceeded_status(power_exceeded_status), .overvoltage_fault(overvoltage_fault),
   .undervoltage_fault(undervoltage_fault), .phase_loss_error(phase_loss_error),
   .phase_loss_warning(phase_loss_warning));
`default_nettype wire

// ==== verification/dbss_partner.sv ====
// Purpose: Machine controller enable and motor speed model
// Assumes: Motor speed in rpm on the drive clock
// Notes: Decel of 8 rpm per cycle keeps braking runs short
`timescale 1ns/1ps
`default_nettype none
module dbss_partner (
   // Clock
   input wire logic clk,
   // Controller request
   input wire logic en_req,
   // Drive state
   input wire logic stage_enable,
   input wire logic controlled_brake,
   input wire logic brake_out,
   // Toward the drive
   output logic enable_pin,
   output logic [15:0] speed_rpm
);
   logic [15:0] speed_r = 16'h0000;
   assign enable_pin = en_req;
   assign speed_rpm = speed_r;
   always_ff @(posedge clk) begin
      if (brake_out) speed_r <= 16'h0000;
      else if (controlled_brake) speed_r <= (speed_r > 16'h0008) ? speed_r - 16'h0008 : 16'h0000;
      else if (stage_enable) speed_r <= 16'h03e8;
      else if (speed_r != 16'h0000) speed_r <= speed_r - 16'h0001; // Coasting is slow on purpose
   end
endmodule // dbss_partner
`default_nettype wire

// ==== verification/dbss_top_tb.sv ====
// Purpose: Self-checking bench of the brake and stop sequencer
// Assumes: 10 MHz clock; long delay and timeout counts are not reached
// Notes: Regen expectations come from a small hysteresis model
`timescale 1ns/1ps
`default_nettype none
module dbss_top_tb;
   logic clk, reset_n, en_req, pl_pin, brk, stp, flt, mode, bus_check, pwr;
   logic [1:0] cls;
   logic [15:0] cmd, vbus, uv;
   wire logic en_pin, stage, cbrk, brake, regen, ready, pstat, ovf, uvf, ple, plw, mre;
   wire logic [15:0] spd, setp, ilim;
   int n_errors = 0, checks = 0, seed = 98, i, k, v, regen_m;
   int on_v[3] = '{400, 720, 840};
   int off_v[3] = '{380, 680, 800};
   int ov_v[3] = '{450, 800, 900};
   dbss_top u_dut (.clk(clk), .reset_n(reset_n), .enable_pin(en_pin), .phase_loss_pin(pl_pin),
      .brake_select(brk), .stop_response_setting(stp), .fault_response_setting(flt),
      .phase_loss_response_mode(mode), .supply_class(cls), .speed_rpm(spd), .speed_cmd(cmd),
      .bus_voltage(vbus), .undervolt_level(uv), .bus_check(bus_check), .power_exceeded(pwr),
      .speed_setpoint(setp), .current_limit(ilim), .stage_enable(stage), .controlled_brake(cbrk),
      .brake_out(brake), .regen_on(regen), .ready_contact(ready), .power_exceeded_status(pstat),
      .overvoltage_fault(ovf), .undervoltage_fault(uvf), .phase_loss_error(ple),
      .phase_loss_warning(plw), .mains_ready_error(mre));
   dbss_partner u_partner (.clk(clk), .en_req(en_req), .stage_enable(stage),
      .controlled_brake(cbrk), .brake_out(brake), .enable_pin(en_pin), .speed_rpm(spd));
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #10;
   endtask
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      checks++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic do_reset();
      reset_n = 1'b0;
      step(16);
      reset_n = 1'b1;
      step(4);
   endtask
   task automatic give_verdict();
      if (n_errors == 0 && checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      n_errors++;
      give_verdict();
   end
   initial begin
      {reset_n, pl_pin, mode, bus_check, pwr, cls} = '0;
      {en_req, brk, stp, flt} = 4'hf;
      vbus = 16'h0150;
      uv = 16'h0100;
      cmd = 16'($random(seed) & 32'h7fff) | 16'h0100;
      do_reset();
      chk("setpoint", cmd, setp);
      chk("brake released", 16'h0000, brake);
      en_req = 1'b0;
      for (i = 0; i < 20 && cbrk !== 1'b1; i++) step(1);
      chk("electrical braking", 16'h0001, cbrk);
      chk("brake open in delay", 16'h0000, brake);
      step(5);
      chk("setpoint ramp", 16'(cmd - 5 * ((cmd + 99999) / 100000)), setp);
      for (i = 0; i < 500 && brake !== 1'b1; i++) step(1);
      chk("brake engaged", 16'h0001, brake);
      step(10);
      chk("brake held", 16'h0001, brake);
      en_req = 1'b1;
      step(10);
      chk("brake released again", 16'h0000, brake);
      {brk, stp, flt} = 3'h0;
      step(2);
      en_req = 1'b0;
      step(6);
      chk("coast stage off", 16'h0000, stage);
      chk("coast no braking", 16'h0000, cbrk);
      chk("no brake output", 16'h0000, brake);
      en_req = 1'b1;
      {stp, flt} = 2'h3;
      step(6);
      for (k = 0; k < 3; k++) begin
         cls = k[1:0];
         regen_m = 0;
         for (i = 0; i < 5; i++) begin
            v = (i == 2) ? on_v[k] : (i == 4) ? off_v[k] : off_v[k] + 1 + {$random(seed)} % 19;
            if (v >= on_v[k]) regen_m = 1;
            else if (v <= off_v[k]) regen_m = 0;
            vbus = 16'(v);
            step(4);
            chk("regen switch", 16'(regen_m), regen);
         end
      end
      {cls, vbus, pl_pin} = {2'h0, 16'h0150, 1'b1};
      step(5);
      chk("warning", 16'h0001, plw);
      chk("current limit", 16'h0028, ilim);
      chk("still enabled", 16'h0001, stage);
      chk("mains ready output", 16'h0001, mre);
      pl_pin = 1'b0;
      step(5);
      chk("limit lifted", 16'hffff, ilim);
      {mode, pl_pin} = 2'h3;
      step(5);
      chk("phase error", 16'h0001, ple);
      chk("phase error ready", 16'h0000, ready);
      chk("emergency ramp", 16'h0001, cbrk);
      {mode, pl_pin} = 2'h0;
      do_reset();
      vbus = 16'h00f0;
      step(4);
      chk("undervoltage", 16'h0001, uvf);
      chk("undervoltage ready", 16'h0000, ready);
      vbus = 16'h0150;
      do_reset();
      pwr = 1'b1;
      step(1);
      pwr = 1'b0;
      vbus = 16'd420;
      step(4);
      chk("power status", 16'h0001, pstat);
      chk("regen stopped", 16'h0000, regen);
      vbus = 16'(ov_v[0]);
      step(4);
      chk("no check no fault", 16'h0000, ovf);
      bus_check = 1'b1;
      step(1);
      bus_check = 1'b0;
      step(4);
      chk("overvoltage", 16'h0001, ovf);
      chk("stage off", 16'h0000, stage);
      chk("ready open", 16'h0000, ready);
      vbus = 16'h0150;
      do_reset();
      chk("ready after reset", 16'h0001, ready);
      give_verdict();
   end
endmodule // dbss_top_tb
`default_nettype wire
